// ==== common/remote_cmd_pkg.sv ====
package remote_cmd_pkg;

	// header classes, top two bits
	localparam logic [1:0] CT_DATA  = 2'b01;
	localparam logic [1:0] CT_RPC   = 2'b10;
	localparam logic [1:0] CT_LOCAL = 2'b11;

	// data command header field positions
	localparam int WR_BIT    = 5;
	localparam int EMB_BIT   = 4;
	localparam int AINC_BIT  = 3;
	localparam int APRES_BIT = 2;

	// memory and procedure table
	localparam int               MEM_AW     = 10;
	localparam int               MEM_BYTES  = 1024;
	localparam logic [15:0]      TABLE_SIZE = 16'h0200;
	localparam int               SLOT_SHIFT = 3;
	localparam logic [7:0]       SLOT_SIZE  = 8'h08;

	// fixed reply values, reset key, timeout reset value and checksum polynomial
	localparam logic [7:0] COOKIE      = 8'h5a;
	localparam logic [7:0] RESET_KEY   = 8'h5a;
	localparam logic [7:0] VERSION     = 8'h01;
	localparam logic [7:0] CRC_ON      = 8'h01;
	localparam logic [7:0] TIMEOUT_RST = 8'hff;
	localparam logic [7:0] CRC_POLY    = 8'h8c;

	// local read codes
	localparam logic [7:0] LR_UNIT    = 8'hc0;
	localparam logic [7:0] LR_STATUS  = 8'hc1;
	localparam logic [7:0] LR_CRCEN   = 8'hc2;
	localparam logic [7:0] LR_ERRCNT  = 8'hc3;
	localparam logic [7:0] LR_ACCESS  = 8'hca;
	localparam logic [7:0] LR_TIMEOUT = 8'hcb;
	localparam logic [7:0] LR_PTR_LO  = 8'hd8;
	localparam logic [7:0] LR_PTR_HI  = 8'hd9;
	localparam logic [7:0] LR_VERSION = 8'hda;
	localparam logic [7:0] LR_UID     = 8'hdb;
	localparam logic [7:0] LR_PITCH   = 8'hdc;
	localparam logic [7:0] LR_TSZ_LO  = 8'hdd;
	localparam logic [7:0] LR_TSZ_HI  = 8'hde;
	localparam logic [7:0] LR_COOKIE  = 8'hdf;

	// local write codes
	localparam logic [7:0] LW_STATUS  = 8'he1;
	localparam logic [7:0] LW_CRCEN   = 8'he2;
	localparam logic [7:0] LW_ERRCNT  = 8'he3;
	localparam logic [7:0] LW_ACCESS  = 8'hea;
	localparam logic [7:0] LW_TIMEOUT = 8'heb;
	localparam logic [7:0] LW_LEDS    = 8'hf7;
	localparam logic [7:0] LW_PTR_LO  = 8'hf8;
	localparam logic [7:0] LW_PTR_HI  = 8'hf9;
	localparam logic [7:0] LW_PTR_ADD = 8'hfa;
	localparam logic [7:0] LW_UID     = 8'hfd;
	localparam logic [7:0] LW_PROC    = 8'hfe;
	localparam logic [7:0] LW_PARSER  = 8'hff;

	// status byte bits
	localparam int         ST_TIMEOUT  = 6;
	localparam int         ST_PROTECT  = 5;
	localparam int         ST_OVERFLOW = 4;
	localparam int         ST_CRC      = 0;
	localparam logic [7:0] ST_MASK     = 8'h79;

	// timing: gap timer ticks in tenths of a character time
	localparam int CLK_NS        = 100;
	localparam int TENTH_CHAR_NS = 8680;
	localparam int TENTH_CYCLES  = TENTH_CHAR_NS / CLK_NS;

	// apb register byte offsets
	localparam logic [7:0] A_STATE   = 8'h00;
	localparam logic [7:0] A_POINTER = 8'h04;
	localparam logic [7:0] A_TIMEOUT = 8'h08;
	localparam logic [7:0] A_LEDS    = 8'h0c;

	// one step of the reflected 8-bit checksum over a byte
	function automatic logic [7:0] crc8_step(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] r;
		logic [7:0] v;
		logic       m;
		r = c;
		v = d;
		for (int i = 0; i < 8; i++)
		begin
			m = r[0] ^ v[0];
			r = r >> 1;
			v = v >> 1;
			if (m)
				r = r ^ CRC_POLY;
		end
		return r;
	endfunction

endpackage

// ==== logic/remote_cmd_parser.sv ====
`timescale 1ns/1ps

//Contract
// - each command opens with one header byte
// - top bits 01 mean data command
// - bit 5 chooses write, else read
// - bit 4 embeds write data in procedures
// - bit 3 advances pointer by length
// - bit 2 means two address bytes follow
// - low bits give 1, 2, 4, 8 bytes
// - multi-byte access walks ascending addresses
// - local read codes return one byte
// - status byte error bit layout
// - checksum enable, count, access, timeout reads
// - pointer, version, id, pitch, size reads
// - code DF returns fixed check byte
// - local writes consume one data byte
// - status, count, access, timeout writes
// - leds, pointer load and pointer add
// - unit id set, keyed processor reset
// - code FF returns parser to idle
// - top bits 10 start procedure 0-63
// - procedures start at 8-byte slots
// - procedure list ends at zero byte
// - table writes need access flag set
// - checksum on commands and all replies
// - character gap timeout resets parser
module remote_cmd_parser (
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic        rx_valid,
	input  wire logic [7:0]  rx_data,
	input  wire logic [7:0]  unit_address,
	output logic             tx_valid,
	output logic [7:0]       tx_data,
	output logic [7:0]       leds,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr
);

	typedef enum logic [2:0] {S_IDLE, S_HDR, S_ALO, S_AHI, S_RD, S_WR, S_LOC, S_CRC} state_t;

	state_t      state_r;
	logic        in_rpc_r;
	logic [15:0] ptr_r;
	logic [15:0] rpc_ptr_r;
	logic [7:0]  hdr_r;
	logic [7:0]  lcode_r;
	logic [2:0]  cnt_r;
	logic [7:0]  mem [remote_cmd_pkg::MEM_BYTES];
	logic [7:0]  status_r;
	logic [7:0]  errcnt_r;
	logic [7:0]  timeout_r;
	logic [7:0]  unit_id_r;
	logic        access_r;
	logic [7:0]  leds_r;
	logic        proc_rst_r;
	logic [7:0]  rep_crc_r;
	logic [7:0]  cmd_crc_r;
	logic [7:0]  tick_r;
	logic [7:0]  gap_r;
	logic [7:0]  tx_data_r;
	logic        tx_valid_r;
	logic [31:0] prdata_r;
	logic        pslverr_r;

	logic        rst_all;
	logic        from_table;
	logic        avail;
	logic [7:0]  in_byte;
	logic [2:0]  len_m1;
	logic [15:0] len16;
	logic [15:0] acc_addr;
	logic        prot;
	logic        rx_take;
	logic        overflow;
	logic        timeout_fire;
	logic        crc_bad;
	logic        loc_we;
	logic        mem_we;
	logic        last_byte;
	logic [7:0]  local_rd;

	// soft reset by keyed write restarts the parser, settings and replies; its own flop, the apb read flops and the byte store are untouched
	assign rst_all = srst | proc_rst_r;

	// byte source: procedure table for headers, addresses and embedded write data of a stored list, else the stream
	always_comb
	begin
		from_table = in_rpc_r && ((state_r == S_HDR) || (state_r == S_ALO)
			|| (state_r == S_AHI) || ((state_r == S_WR) && hdr_r[remote_cmd_pkg::EMB_BIT]));
		avail   = from_table | rx_valid;
		in_byte = from_table ? mem[rpc_ptr_r[remote_cmd_pkg::MEM_AW-1:0]] : rx_data;
	end

	// size code to byte count
	always_comb
	begin
		case (hdr_r[1:0])
			2'b00:   len_m1 = 3'h0;
			2'b01:   len_m1 = 3'h1;
			2'b10:   len_m1 = 3'h3;
			default: len_m1 = 3'h7;
		endcase
		len16 = {13'h0000, len_m1} + 16'h0001;
	end

	// access address walks upward from the pointer
	assign acc_addr  = ptr_r + {13'h0000, cnt_r};
	assign last_byte = (cnt_r == len_m1);
	// guard the wrapped address, else an alias above the store reaches the table
	assign prot      = ({6'h00, acc_addr[remote_cmd_pkg::MEM_AW-1:0]} < remote_cmd_pkg::TABLE_SIZE)
		&& !access_r;
	assign mem_we    = (state_r == S_WR) && avail && !prot && !timeout_fire;

	// bytes that the parser cannot take while busy are lost and flagged
	assign rx_take = rx_valid && ((state_r == S_IDLE) || (state_r == S_LOC)
		|| (state_r == S_CRC) || (((state_r == S_ALO) || (state_r == S_AHI)
		|| (state_r == S_WR)) && !from_table));
	assign overflow = rx_valid && !rx_take;

	assign timeout_fire = (state_r != S_IDLE) && (gap_r > timeout_r);
	assign crc_bad = (state_r == S_CRC) && rx_valid
		&& (remote_cmd_pkg::crc8_step(cmd_crc_r, rx_data) != 8'h00);
	assign loc_we  = (state_r == S_LOC) && rx_valid && !timeout_fire;

	// local read answers, one byte each
	always_comb
	begin
		case (rx_data)
			remote_cmd_pkg::LR_UNIT:    local_rd = unit_address;
			remote_cmd_pkg::LR_STATUS:  local_rd = status_r;
			remote_cmd_pkg::LR_CRCEN:   local_rd = remote_cmd_pkg::CRC_ON;
			remote_cmd_pkg::LR_ERRCNT:  local_rd = errcnt_r;
			remote_cmd_pkg::LR_ACCESS:  local_rd = {7'h00, access_r};
			remote_cmd_pkg::LR_TIMEOUT: local_rd = timeout_r;
			remote_cmd_pkg::LR_PTR_LO:  local_rd = ptr_r[7:0];
			remote_cmd_pkg::LR_PTR_HI:  local_rd = ptr_r[15:8];
			remote_cmd_pkg::LR_VERSION: local_rd = remote_cmd_pkg::VERSION;
			remote_cmd_pkg::LR_UID:     local_rd = unit_id_r;
			remote_cmd_pkg::LR_PITCH:   local_rd = remote_cmd_pkg::SLOT_SIZE;
			remote_cmd_pkg::LR_TSZ_LO:  local_rd = remote_cmd_pkg::TABLE_SIZE[7:0];
			remote_cmd_pkg::LR_TSZ_HI:  local_rd = remote_cmd_pkg::TABLE_SIZE[15:8];
			remote_cmd_pkg::LR_COOKIE:  local_rd = remote_cmd_pkg::COOKIE;
			default:                    local_rd = 8'h00;
		endcase
	end

	// command parser
	always_ff @(posedge clk)
	begin
		if (rst_all)
		begin
			state_r   <= S_IDLE;
			in_rpc_r  <= 1'b0;
			ptr_r     <= 16'h0000;
			rpc_ptr_r <= 16'h0000;
			hdr_r     <= 8'h00;
			lcode_r   <= 8'h00;
			cnt_r     <= 3'h0;
		end
		else if (timeout_fire)
		begin
			state_r  <= S_IDLE;
			in_rpc_r <= 1'b0;
		end
		else
		begin
			if (avail && from_table)
				rpc_ptr_r <= rpc_ptr_r + 16'h0001;
			case (state_r)
				S_IDLE:
				if (rx_valid)
				begin
					case (rx_data[7:6])
						remote_cmd_pkg::CT_DATA:
						begin
							hdr_r <= rx_data;
							cnt_r <= 3'h0;
							if (rx_data[remote_cmd_pkg::APRES_BIT])
								state_r <= S_ALO;
							else
								state_r <= rx_data[remote_cmd_pkg::WR_BIT] ? S_WR : S_RD;
						end
						remote_cmd_pkg::CT_RPC:
						begin
							rpc_ptr_r <= {10'h000, rx_data[5:0]} << remote_cmd_pkg::SLOT_SHIFT;
							in_rpc_r  <= 1'b1;
							state_r   <= S_HDR;
						end
						remote_cmd_pkg::CT_LOCAL:
						begin
							lcode_r <= rx_data;
							if (rx_data == remote_cmd_pkg::LW_PARSER)
								state_r <= S_IDLE;
							else
								state_r <= rx_data[remote_cmd_pkg::WR_BIT] ? S_LOC : S_CRC;
						end
						default:
							state_r <= S_IDLE; // zero byte between commands is skipped
					endcase
				end
				S_HDR:
				if (in_byte[7:6] == remote_cmd_pkg::CT_DATA)
				begin
					hdr_r <= in_byte;
					cnt_r <= 3'h0;
					if (in_byte[remote_cmd_pkg::APRES_BIT])
						state_r <= S_ALO;
					else
						state_r <= in_byte[remote_cmd_pkg::WR_BIT] ? S_WR : S_RD;
				end
				else
				begin
					in_rpc_r <= 1'b0;
					state_r  <= S_CRC;
				end
				S_ALO:
				if (avail)
				begin
					ptr_r[7:0] <= in_byte;
					state_r    <= S_AHI;
				end
				S_AHI:
				if (avail)
				begin
					ptr_r[15:8] <= in_byte;
					state_r     <= hdr_r[remote_cmd_pkg::WR_BIT] ? S_WR : S_RD;
				end
				S_RD, S_WR:
				if ((state_r == S_RD) || avail)
				begin
					cnt_r <= cnt_r + 3'h1;
					if (last_byte)
					begin
						if (hdr_r[remote_cmd_pkg::AINC_BIT])
							ptr_r <= ptr_r + len16;
						state_r <= in_rpc_r ? S_HDR : S_CRC;
					end
				end
				S_LOC:
				if (rx_valid)
				begin
					case (lcode_r)
						remote_cmd_pkg::LW_PTR_LO:  ptr_r[7:0]  <= rx_data;
						remote_cmd_pkg::LW_PTR_HI:  ptr_r[15:8] <= rx_data;
						remote_cmd_pkg::LW_PTR_ADD: ptr_r <= ptr_r + {8'h00, rx_data};
						default:                    ptr_r <= ptr_r;
					endcase
					state_r <= S_CRC;
				end
				S_CRC:
				if (rx_valid)
				begin
					in_rpc_r <= 1'b0;
					state_r  <= S_IDLE;
				end
				default:
					state_r <= S_IDLE;
			endcase
		end
	end

	// byte store; no reset, contents survive a soft reset
	always_ff @(posedge clk)
	begin
		if (mem_we)
			mem[acc_addr[remote_cmd_pkg::MEM_AW-1:0]] <= in_byte;
	end

	// command checksum over stream bytes only
	always_ff @(posedge clk)
	begin
		if (rst_all)
			cmd_crc_r <= 8'h00;
		else if ((state_r == S_IDLE) && rx_valid)
			cmd_crc_r <= remote_cmd_pkg::crc8_step(8'h00, rx_data);
		else if (rx_take)
			cmd_crc_r <= remote_cmd_pkg::crc8_step(cmd_crc_r, rx_data);
	end

	// reply bytes; the closing checksum is zero when no data was returned
	always_ff @(posedge clk)
	begin
		if (rst_all)
		begin
			tx_valid_r <= 1'b0;
			tx_data_r  <= 8'h00;
			rep_crc_r  <= 8'h00;
		end
		else
		begin
			tx_valid_r <= 1'b0;
			if ((state_r == S_IDLE) && rx_valid)
			begin
				if ((rx_data[7:6] == remote_cmd_pkg::CT_LOCAL) && !rx_data[remote_cmd_pkg::WR_BIT])
				begin
					tx_valid_r <= 1'b1;
					tx_data_r  <= local_rd;
					rep_crc_r  <= remote_cmd_pkg::crc8_step(8'h00, local_rd);
				end
				else
					rep_crc_r <= 8'h00;
			end
			else if (state_r == S_RD)
			begin
				tx_valid_r <= 1'b1;
				tx_data_r  <= mem[acc_addr[remote_cmd_pkg::MEM_AW-1:0]];
				rep_crc_r  <= remote_cmd_pkg::crc8_step(rep_crc_r,
					mem[acc_addr[remote_cmd_pkg::MEM_AW-1:0]]);
			end
			else if ((state_r == S_CRC) && rx_valid && !timeout_fire)
			begin
				tx_valid_r <= 1'b1;
				tx_data_r  <= rep_crc_r;
			end
		end
	end

	// character gap timer, counted in tenths of a character time
	always_ff @(posedge clk)
	begin
		if (rst_all || rx_valid || (state_r == S_IDLE) || from_table || (state_r == S_RD))
		begin
			tick_r <= 8'h00;
			gap_r  <= 8'h00;
		end
		else if (tick_r == 8'(remote_cmd_pkg::TENTH_CYCLES - 1))
		begin
			tick_r <= 8'h00;
			if (gap_r != 8'hff)
				gap_r <= gap_r + 8'h01;
		end
		else
			tick_r <= tick_r + 8'h01;
	end

	// local settings and error flags; a new error wins over a clearing write
	always_ff @(posedge clk)
	begin
		if (rst_all)
		begin
			status_r  <= 8'h00;
			errcnt_r  <= 8'h00;
			timeout_r <= remote_cmd_pkg::TIMEOUT_RST;
			unit_id_r <= 8'h00;
			access_r  <= 1'b0;
			leds_r    <= 8'h00;
		end
		else
		begin
			status_r <= ((loc_we && (lcode_r == remote_cmd_pkg::LW_STATUS))
				? (rx_data & remote_cmd_pkg::ST_MASK) : status_r)
				| ({7'h00, timeout_fire} << remote_cmd_pkg::ST_TIMEOUT)
				| ({7'h00, (state_r == S_WR) && avail && prot} << remote_cmd_pkg::ST_PROTECT)
				| ({7'h00, overflow} << remote_cmd_pkg::ST_OVERFLOW)
				| ({7'h00, crc_bad} << remote_cmd_pkg::ST_CRC);
			errcnt_r <= ((loc_we && (lcode_r == remote_cmd_pkg::LW_ERRCNT)) ? rx_data : errcnt_r)
				+ {7'h00, crc_bad};
			if (loc_we && (lcode_r == remote_cmd_pkg::LW_ACCESS))
				access_r <= (rx_data != 8'h00);
			if (loc_we && (lcode_r == remote_cmd_pkg::LW_TIMEOUT))
				timeout_r <= rx_data;
			else if (psel && penable && pwrite && (paddr == remote_cmd_pkg::A_TIMEOUT))
				timeout_r <= pwdata[7:0];
			if (loc_we && (lcode_r == remote_cmd_pkg::LW_LEDS))
				leds_r <= rx_data;
			if (loc_we && (lcode_r == remote_cmd_pkg::LW_UID))
				unit_id_r <= rx_data;
		end
	end

	// keyed processor reset pulse; only the power-on reset clears it
	always_ff @(posedge clk)
	begin
		if (srst)
			proc_rst_r <= 1'b0;
		else
			proc_rst_r <= loc_we && (lcode_r == remote_cmd_pkg::LW_PROC)
				&& (rx_data == remote_cmd_pkg::RESET_KEY);
	end

	// apb slave: read data captured in the setup cycle, zero wait states
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			prdata_r  <= 32'h00000000;
			pslverr_r <= 1'b0;
		end
		else if (psel && !penable)
		begin
			pslverr_r <= 1'b0;
			case (paddr)
				remote_cmd_pkg::A_STATE:
					prdata_r <= {7'h00, access_r, errcnt_r, status_r, 5'h00, 3'(state_r)};
				remote_cmd_pkg::A_POINTER: prdata_r <= {16'h0000, ptr_r};
				remote_cmd_pkg::A_TIMEOUT: prdata_r <= {24'h000000, timeout_r};
				remote_cmd_pkg::A_LEDS:    prdata_r <= {24'h000000, leds_r};
				default:
				begin
					prdata_r  <= 32'h00000000;
					pslverr_r <= 1'b1;
				end
			endcase
		end
	end

	assign pready   = psel & penable;
	assign prdata   = prdata_r;
	assign pslverr  = pslverr_r & psel & penable;
	assign tx_valid = tx_valid_r;
	assign tx_data  = tx_data_r;
	assign leds     = leds_r;

	chk_cookie_reply: assert property (
		@(posedge clk) disable iff (rst_all)
		(state_r == S_IDLE && rx_valid && rx_data == remote_cmd_pkg::LR_COOKIE)
		|=> tx_valid && tx_data == remote_cmd_pkg::COOKIE ##1 !tx_valid)
		else $error("check byte reply wrong");

	chk_status_reply: assert property (
		@(posedge clk) disable iff (rst_all)
		(state_r == S_IDLE && rx_valid && rx_data == remote_cmd_pkg::LR_STATUS)
		|=> tx_valid && tx_data == $past(status_r) && state_r == S_CRC)
		else $error("status reply wrong");

	chk_four_byte_read: assert property (
		@(posedge clk) disable iff (rst_all)
		(state_r == S_IDLE && rx_valid && rx_data == 8'h4a)
		|=> !tx_valid ##1 tx_valid[*4] ##1 (!tx_valid && state_r == S_CRC))
		else $error("four byte read length wrong");

	chk_ptr_advance: assert property (
		@(posedge clk) disable iff (rst_all)
		(state_r == S_RD && last_byte && hdr_r[remote_cmd_pkg::AINC_BIT])
		|=> ptr_r == $past(ptr_r) + $past(len16))
		else $error("pointer not advanced by length");

	chk_ptr_hold: assert property (
		@(posedge clk) disable iff (rst_all)
		(state_r == S_RD && !hdr_r[remote_cmd_pkg::AINC_BIT]) |=> $stable(ptr_r))
		else $error("pointer moved without advance bit");

	chk_table_guard: assert property (
		@(posedge clk) disable iff (rst_all)
		(state_r == S_WR && avail && prot && !timeout_fire)
		|-> !mem_we ##1 status_r[remote_cmd_pkg::ST_PROTECT])
		else $error("protected table write not refused");

	chk_gap_reset: assert property (
		@(posedge clk) disable iff (rst_all)
		timeout_fire |=> state_r == S_IDLE && status_r[remote_cmd_pkg::ST_TIMEOUT] && !in_rpc_r)
		else $error("gap timeout did not reset parser");

	chk_zero_crc: assert property (
		@(posedge clk) disable iff (rst_all)
		(state_r == S_IDLE && rx_valid && rx_data == remote_cmd_pkg::LW_LEDS)
		##1 (rx_valid && !timeout_fire) ##1 (rx_valid && !timeout_fire)
		|=> tx_valid && tx_data == 8'h00)
		else $error("write reply checksum not zero");

	chk_proc_start: assert property (
		@(posedge clk) disable iff (rst_all)
		(state_r == S_IDLE && rx_valid && rx_data[7:6] == remote_cmd_pkg::CT_RPC)
		|=> state_r == S_HDR && in_rpc_r && rpc_ptr_r == {7'h00, $past(rx_data[5:0]), 3'h0})
		else $error("procedure start slot wrong");

	chk_parser_idle: assert property (
		@(posedge clk) disable iff (rst_all)
		(state_r == S_IDLE && rx_valid && rx_data == remote_cmd_pkg::LW_PARSER)
		|=> state_r == S_IDLE && !tx_valid)
		else $error("parser reset code mishandled");

endmodule

// ==== tb/host_link_model.sv ====
`timescale 1ns/1ps

module host_link_model (
	input  wire logic       clk,
	output logic            rx_valid,
	output logic [7:0]      rx_data,
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_data
);
	logic [7:0] crc;
	logic [7:0] q[$];

	// reflected checksum step, kept apart from the design's own copy
	function automatic logic [7:0] step(input logic [7:0] c, input logic [7:0] d);
		logic m;
		for (int i = 0; i < 8; i++)
		begin
			m = c[0] ^ d[0];
			c = c >> 1;
			d = d >> 1;
			if (m)
				c = c ^ 8'h8c;
		end
		return c;
	endfunction

	// line idle at time zero
	initial
	begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		crc = 8'h00;
	end

	// one byte per edge, header first, address low byte first
	task put(input logic [7:0] b);
		@(posedge clk);
		rx_valid <= 1'b1;
		rx_data <= b;
		crc = step(crc, b);
	endtask

	// released line shows the inverse, so a stale byte cannot pass
	task rel();
		@(posedge clk);
		rx_valid <= 1'b0;
		rx_data <= ~rx_data;
	endtask

	// reply strobes stand one cycle, so take them at every edge
	always @(posedge clk)
		if (tx_valid)
			q.push_back(tx_data);
endmodule

// ==== tb/remote_serial_byte_command_parser_tb_top.sv ====
`timescale 1ns/1ps

module remote_serial_byte_command_parser_tb_top;
	logic        clk, srst, rx_valid, tx_valid, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]  rx_data, unit_address, tx_data, leds, paddr;
	logic [31:0] pwdata, prdata, rd;
	int          miscompares, n_compared, cyc;
	logic [7:0]  sq[$];
	logic [7:0]  eq[$];
	logic [15:0] rows[14];

	remote_cmd_parser dut (.clk(clk), .srst(srst), .rx_valid(rx_valid), .rx_data(rx_data),
		.unit_address(unit_address), .tx_valid(tx_valid), .tx_data(tx_data), .leds(leds),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));

	host_link_model host (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data),
		.tx_valid(tx_valid), .tx_data(tx_data));

	// 10 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task conclude();
		$display("compared %0d, mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// hang guard: the whole run needs about a thousand cycles
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			miscompares++;
			$display("unexpected at %0t: run hung", $time);
			conclude();
		end
	end

	task chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
		n_compared++;
		if (got !== exp)
		begin
			miscompares++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	task chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_compared++;
		if (got !== exp)
		begin
			miscompares++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	// one command: send sq, wait for the eq replies, then checksum and its reply
	task xchg(input bit reply);
		int k;
		logic [7:0] r;
		host.q.delete();
		host.crc = 8'h00;
		foreach (sq[i])
			host.put(sq[i]);
		// no reply data to wait for: checksum follows at once
		if (!reply || eq.size() > 0)
			host.rel();
		if (!reply)
		begin
			repeat (6) @(posedge clk);
			chk8(8'(host.q.size()), 8'h00, "silent command");
			return;
		end
		k = 0;
		while (host.q.size() < eq.size() && k < 60)
		begin
			@(posedge clk);
			k++;
		end
		host.put(host.crc);
		host.rel();
		repeat (4) @(posedge clk);
		chk8(8'(host.q.size()), 8'(eq.size() + 1), "reply count");
		r = 8'h00;
		foreach (eq[i])
		begin
			chk8(host.q[i], eq[i], "reply byte");
			r = host.step(r, eq[i]);
		end
		chk8(host.q[eq.size()], r, "reply checksum");
	endtask

	// request held until pready is sampled high at a rising edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// no limit of its own: only the hang guard ends a wait that pready never closes
		do
		begin
			@(posedge clk);
		end
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// main sequence
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		unit_address = 8'h3c;
		srst = 1'b1;
		rows = '{16'hc03c, 16'hc100, 16'hc201, 16'hc300, 16'hca00, 16'hcbff, 16'hd800,
			16'hd900, {8'hda, remote_cmd_pkg::VERSION}, 16'hdb00, 16'hdc08,
			{8'hdd, remote_cmd_pkg::TABLE_SIZE[7:0]}, {8'hde, remote_cmd_pkg::TABLE_SIZE[15:8]},
			16'hdf5a};
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		chk8({7'h00, tx_valid}, 8'h00, "idle strobe");
		chk8(leds, 8'h00, "leds at reset");
		apb(1'b0, remote_cmd_pkg::A_TIMEOUT, 32'h0);
		chk32(rd, 32'h000000ff, "timeout word");
		apb(1'b0, 8'h10, 32'h0);
		chk32({rd[30:0], err}, 32'h1, "unmapped");
		$display("reset test done");
		// local read codes at reset state
		foreach (rows[i])
		begin
			sq = {rows[i][15:8]};
			eq = {rows[i][7:0]};
			xchg(1);
		end
		$display("local read table done");
		sq = {8'h6e, 8'h10, 8'h02, 8'haa, 8'hbb, 8'hcc, 8'hdd};
		eq = {};
		xchg(1);
		sq = {8'h61, 8'hee, 8'hff};
		xchg(1);
		sq = {8'hd8};
		eq = {8'h14};
		xchg(1);
		sq = {8'h6f, 8'h16, 8'h02, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77, 8'h88};
		eq = {};
		xchg(1);
		sq = {8'h47, 8'h12, 8'h02};
		eq = {8'hcc, 8'hdd, 8'hee, 8'hff, 8'h11, 8'h22, 8'h33, 8'h44};
		xchg(1);
		sq = {8'h40};
		eq = {8'hcc};
		xchg(1);
		$display("data command test done");
		eq = {};
		sq = {8'hf8, 8'h10};
		xchg(1);
		sq = {8'hf9, 8'h02};
		xchg(1);
		sq = {8'hfa, 8'h05};
		xchg(1);
		sq = {8'hf7, 8'ha5};
		xchg(1);
		chk8(leds, 8'ha5, "leds");
		sq = {8'h40};
		eq = {8'hff};
		xchg(1);
		sq = {8'h4a};
		eq = {8'hff, 8'h11, 8'h22, 8'h33};
		xchg(1);
		sq = {8'hd8};
		eq = {8'h19};
		xchg(1);
		$display("pointer and leds test done");
		eq = {};
		sq = {8'h64, 8'h08, 8'h00, 8'h11};
		xchg(1);
		sq = {8'hc1};
		eq = {8'h20};
		xchg(1);
		eq = {};
		sq = {8'he1, 8'h00};
		xchg(1);
		sq = {8'he3, 8'h05};
		xchg(1);
		sq = {8'hc1};
		eq = {8'h00};
		xchg(1);
		sq = {8'hc3};
		eq = {8'h05};
		xchg(1);
		$display("status test done");
		eq = {};
		sq = {8'hea, 8'h01};
		xchg(1);
		sq = {8'h6f, 8'h08, 8'h00, 8'h75, 8'h30, 8'h02, 8'h12, 8'h34, 8'h45, 8'h30, 8'h02};
		xchg(1);
		sq = {8'h64, 8'h10, 8'h00, 8'h00};
		xchg(1);
		sq = {8'hea, 8'h00};
		xchg(1);
		sq = {8'h81};
		eq = {8'h12, 8'h34};
		xchg(1);
		$display("procedure test done");
		sq = {8'hff};
		xchg(0);
		sq = {8'hdf};
		eq = {8'h5a};
		xchg(1);
		eq = {};
		sq = {8'hfd, 8'h77};
		xchg(1);
		sq = {8'hfe, 8'h00};
		xchg(1);
		sq = {8'hdb};
		eq = {8'h77};
		xchg(1);
		sq = {8'hfe, 8'h5a};
		xchg(0);
		sq = {8'hdb};
		eq = {8'h00};
		xchg(1);
		chk8(leds, 8'h00, "leds after soft reset");
		$display("abort and soft reset test done");
		eq = {};
		sq = {8'heb, 8'h01};
		xchg(1);
		sq = {8'h46};
		xchg(0);
		repeat (300) @(posedge clk);
		sq = {8'hc1};
		eq = {8'h40};
		xchg(1);
		apb(1'b1, remote_cmd_pkg::A_TIMEOUT, 32'h00000033);
		sq = {8'hcb};
		eq = {8'h33};
		xchg(1);
		$display("timeout test done");
		// corrupt checksum, then a byte sent into a running read
		host.crc = 8'h00;
		host.put(8'hf7);
		host.put(8'h3c);
		host.put(host.crc ^ 8'h01);
		host.put(8'h40);
		host.put(8'h00);
		host.put(host.step(8'h00, 8'h40));
		host.rel();
		repeat (4) @(posedge clk);
		chk8(leds, 8'h3c, "write before checksum");
		sq = {8'hc1};
		eq = {8'h51};
		xchg(1);
		sq = {8'hc3};
		eq = {8'h01};
		xchg(1);
		$display("checksum and overflow test done");
		conclude();
	end
endmodule
